// >>> verilog/fbc_host.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module fbc_host (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // Flash pins
  output logic      [fbc_pkg::ADDR_W-1:0] flash_addr,
  input  wire logic [fbc_pkg::DATA_W-1:0] flash_dq_in,
  output logic      [fbc_pkg::DATA_W-1:0] flash_dq_out,
  output logic                            flash_dq_oe,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n,
  output logic                            flash_reset_n,
  output logic                            byte_word_select,
  output logic                            protect_accelerate_input,
  input  wire logic                       ready_busy_n_output
);

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b011,
    ST_READ  = 3'b010,
    ST_POLL  = 3'b110,
    ST_NEXT  = 3'b111
  } fbc_state_t;

  fbc_state_t             state_reg, state_next;
  fbc_pkg::fbc_cycle_t    cyc_reg;
  logic [fbc_pkg::ADDR_W-1:0] addr_reg;
  logic [fbc_pkg::DATA_W-1:0] wdata_reg, rdata_reg, dq_last_reg;
  logic [3:0]             op_reg;
  logic [2:0]             step_reg, nsteps_reg;
  logic [3:0]             tcnt_reg;
  logic [15:0]            poll_cnt_reg;
  logic                   busy_reg, timeout_reg, fail_reg;
  logic                   byp_reg, as_reg, aux_reg, accel_reg, byte_reg, hwrst_reg;
  logic                   poll_reg;
  logic [fbc_pkg::DATA_W-1:0] dq_s1, dq_s2;
  logic                   rb_s1, rb_s2;

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk) begin
    dq_s1 <= flash_dq_in;
    dq_s2 <= dq_s1;
    rb_s1 <= ready_busy_n_output;
    rb_s2 <= rb_s1;
  end

  // ==========================================================================
  // Command decode
  wire wr_ctrl  = reg_wr && reg_addr == fbc_pkg::REG_CTRL;
  wire wr_addr  = reg_wr && reg_addr == fbc_pkg::REG_ADDR;
  wire wr_wdata = reg_wr && reg_addr == fbc_pkg::REG_WDATA;
  wire [3:0] new_op = reg_wdata[3:0];
  wire start = wr_ctrl && !busy_reg && new_op != 4'(fbc_pkg::OP_NONE);

  // Number of bus cycles for each opcode
  // four-cycle program
  wire [2:0] steps_of =
    (new_op == 4'(fbc_pkg::OP_PROGRAM))  ? 3'd4 :
    (new_op == 4'(fbc_pkg::OP_AUTOSEL))  ? 3'd3 :
    (new_op == 4'(fbc_pkg::OP_BYPASS))   ? 3'd3 :
    (new_op == 4'(fbc_pkg::OP_AUX_IN))   ? 3'd3 :
    (new_op == 4'(fbc_pkg::OP_AUX_OUT))  ? 3'd4 :
    (new_op == 4'(fbc_pkg::OP_BYP_PROG)) ? 3'd2 :
    (new_op == 4'(fbc_pkg::OP_BYP_EXIT)) ? 3'd2 : 3'd1;

  // Address and data of the current step
  fbc_pkg::fbc_cycle_t step_cyc;
  wire is_u1 = step_reg == 3'd0;
  wire is_u2 = step_reg == 3'd1;
  wire [fbc_pkg::DATA_W-1:0] u1d = {8'h00, fbc_pkg::UNLOCK1_DATA};
  wire [fbc_pkg::DATA_W-1:0] u2d = {8'h00, fbc_pkg::UNLOCK2_DATA};
  always_comb begin
    step_cyc = '{addr: addr_reg, data: wdata_reg};
    unique case (op_reg)
      4'(fbc_pkg::OP_PROGRAM), 4'(fbc_pkg::OP_AUTOSEL), 4'(fbc_pkg::OP_BYPASS),
      4'(fbc_pkg::OP_AUX_IN), 4'(fbc_pkg::OP_AUX_OUT): begin
        if (is_u1)
          step_cyc = '{addr: fbc_pkg::UNLOCK1_ADDR, data: u1d};
        else if (is_u2)
          step_cyc = '{addr: fbc_pkg::UNLOCK2_ADDR, data: u2d};
        else if (step_reg == 3'd2) begin
          step_cyc.addr = (op_reg == 4'(fbc_pkg::OP_AUTOSEL)) ? addr_reg
                                                              : fbc_pkg::UNLOCK1_ADDR;
          step_cyc.data = {8'h00,
            (op_reg == 4'(fbc_pkg::OP_PROGRAM)) ? fbc_pkg::CMD_PROGRAM :
            (op_reg == 4'(fbc_pkg::OP_AUTOSEL)) ? fbc_pkg::CMD_AUTOSEL :
            (op_reg == 4'(fbc_pkg::OP_BYPASS))  ? fbc_pkg::CMD_BYPASS  :
            (op_reg == 4'(fbc_pkg::OP_AUX_IN))  ? fbc_pkg::CMD_AUX_ENTER :
                                                  fbc_pkg::CMD_AUX_EXIT1};
        end else if (op_reg == 4'(fbc_pkg::OP_AUX_OUT))
          step_cyc.data = {8'h00, fbc_pkg::CMD_AUX_EXIT2};
      end
      4'(fbc_pkg::OP_BYP_PROG): begin
        if (is_u1)
          step_cyc.data = {8'h00, fbc_pkg::CMD_PROGRAM};
      end
      4'(fbc_pkg::OP_BYP_EXIT): begin
        // 90h at bank address, then 00h
        step_cyc.data = {8'h00, is_u1 ? fbc_pkg::CMD_BYP_RESET : fbc_pkg::CMD_BYP_EXIT};
      end
      4'(fbc_pkg::OP_RESET): begin
        step_cyc.data = {8'h00, fbc_pkg::CMD_RESET};
      end
      default: ;
    endcase
  end

  wire last_step = step_reg + 3'd1 == nsteps_reg;
  wire is_prog = op_reg == 4'(fbc_pkg::OP_PROGRAM) || op_reg == 4'(fbc_pkg::OP_BYP_PROG);
  wire is_rd   = op_reg == 4'(fbc_pkg::OP_READ);
  wire tdone   = tcnt_reg == 4'd0;

  // Polling: toggle bit stops toggling and polling bit matches data when done
  // status bits
  wire tog_stop = dq_s2[fbc_pkg::TOGGLE_BIT] == dq_last_reg[fbc_pkg::TOGGLE_BIT];
  wire poll_ok  = dq_s2[fbc_pkg::POLL_BIT] == wdata_reg[fbc_pkg::POLL_BIT];
  // Read data reach dq_s2 only two edges after the output enable falls
  wire poll_live = poll_cnt_reg > 16'h0001;
  wire to_seen  = dq_s2[fbc_pkg::TIMEOUT_BIT] && !rb_s2;
  wire poll_end = poll_reg && tdone && poll_live &&
                  ((tog_stop && poll_ok && rb_s2) || to_seen ||
                   poll_cnt_reg == fbc_pkg::POLL_LIMIT);

  // ==========================================================================
  // State machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (start) state_next = ST_SETUP;
      ST_SETUP: if (tdone) state_next = is_rd ? ST_READ : ST_WRITE;
      ST_WRITE: if (tdone) state_next = ST_NEXT;
      ST_READ:  if (tdone) state_next = ST_NEXT;
      ST_NEXT:  if (tdone)
                  state_next = (!last_step) ? ST_SETUP :
                               (is_prog) ? ST_POLL : ST_IDLE;
      ST_POLL:  if (poll_end) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      tcnt_reg     <= 4'h0;
      step_reg     <= 3'd0;
      nsteps_reg   <= 3'd1;
      op_reg       <= 4'h0;
      busy_reg     <= 1'b0;
      poll_reg     <= 1'b0;
      poll_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      tcnt_reg  <= (state_next != state_reg) ? fbc_pkg::STROBE_CYC :
                   (tdone ? 4'h0 : tcnt_reg - 4'd1);
      if (start) begin
        op_reg     <= new_op;
        nsteps_reg <= steps_of;
        step_reg   <= 3'd0;
        busy_reg   <= 1'b1;
      end else if (state_reg == ST_NEXT && tdone && !last_step)
        step_reg <= step_reg + 3'd1;
      if (state_next == ST_IDLE && state_reg != ST_IDLE)
        busy_reg <= 1'b0;
      poll_reg     <= state_reg == ST_POLL && !poll_reg ? 1'b1 :
                      (state_reg == ST_POLL ? ~poll_reg : 1'b0);
      poll_cnt_reg <= state_reg == ST_POLL ? poll_cnt_reg + 16'd1 : 16'h0000;
    end
  end

  // ==========================================================================
  // Data, mode tracking and pins
  wire done_now = state_reg != ST_IDLE && state_next == ST_IDLE;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_reg    <= '0;
      wdata_reg   <= '0;
      rdata_reg   <= '0;
      dq_last_reg <= '0;
      timeout_reg <= 1'b0;
      fail_reg    <= 1'b0;
      byp_reg     <= 1'b0;
      as_reg      <= 1'b0;
      aux_reg     <= 1'b0;
      accel_reg   <= 1'b0;
      byte_reg    <= 1'b0;
      hwrst_reg   <= 1'b1;
      cyc_reg     <= '0;
    end else begin
      if (wr_addr)  addr_reg  <= reg_wdata[fbc_pkg::ADDR_W-1:0];
      if (wr_wdata) wdata_reg <= reg_wdata[fbc_pkg::DATA_W-1:0];
      if (wr_ctrl) begin
        byte_reg  <= reg_wdata[4];
        accel_reg <= reg_wdata[5];
        hwrst_reg <= !reg_wdata[6];
      end
      if (state_reg == ST_SETUP) cyc_reg <= step_cyc;
      // Synchroniser delay: the sample taken in READ arrives one edge into NEXT
      if (state_reg == ST_NEXT && is_rd && !tdone) rdata_reg <= dq_s2;
      if (state_reg == ST_POLL && poll_reg) dq_last_reg <= dq_s2;
      if (start) begin
        timeout_reg <= 1'b0;
        fail_reg    <= 1'b0;
      end
      if (state_reg == ST_POLL && poll_end && !(tog_stop && poll_ok && rb_s2)) begin
        // timeout seen, host must send reset
        timeout_reg <= 1'b1;
        fail_reg    <= 1'b1;
      end
      if (done_now) begin
        unique case (op_reg)
          4'(fbc_pkg::OP_AUTOSEL): as_reg  <= 1'b1;
          4'(fbc_pkg::OP_BYPASS):  byp_reg <= 1'b1;
          4'(fbc_pkg::OP_BYP_EXIT): byp_reg <= 1'b0;
          4'(fbc_pkg::OP_AUX_IN):  aux_reg <= 1'b1;
          4'(fbc_pkg::OP_AUX_OUT): aux_reg <= 1'b0;
          4'(fbc_pkg::OP_RESET): begin
            as_reg      <= 1'b0;
            timeout_reg <= 1'b0;
          end
          default: ;
        endcase
      end
      if (accel_reg) byp_reg <= 1'b1;
      if (!hwrst_reg) begin
        as_reg  <= 1'b0;
        aux_reg <= 1'b0;
        byp_reg <= 1'b0;
      end
    end
  end

  // address set before we_n falls, data held past rise
  assign flash_addr    = cyc_reg.addr;
  assign flash_dq_out  = cyc_reg.data;
  assign flash_dq_oe   = state_reg == ST_WRITE || (state_reg == ST_NEXT && !is_rd);
  assign flash_we_n    = state_reg != ST_WRITE;
  assign flash_oe_n    = !(state_reg == ST_READ || state_reg == ST_POLL);
  assign flash_ce_n    = state_reg == ST_IDLE;
  assign flash_reset_n = hwrst_reg;
  assign byte_word_select         = !byte_reg;
  assign protect_accelerate_input = accel_reg;

  // ==========================================================================
  // Register read
  fbc_pkg::fbc_status_t st;
  assign st = '{busy: busy_reg, timeout: timeout_reg, prog_fail: fail_reg,
                in_bypass: byp_reg, in_autosel: as_reg, in_aux: aux_reg,
                accel: accel_reg, rdy: rb_s2};
  wire [31:0] rd_mux =
    (reg_addr == fbc_pkg::REG_CTRL)   ? {25'h0, !hwrst_reg, accel_reg, byte_reg, op_reg} :
    (reg_addr == fbc_pkg::REG_ADDR)   ? {11'h0, addr_reg} :
    (reg_addr == fbc_pkg::REG_WDATA)  ? {16'h0, wdata_reg} :
    (reg_addr == fbc_pkg::REG_RDATA)  ? {16'h0, rdata_reg} :
    (reg_addr == fbc_pkg::REG_STATUS) ? {24'h0, st} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!reset_n)    reg_rdata <= 32'h0000_0000;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

endmodule

// >>> verilog/fbc_pkg.sv
package fbc_pkg;

  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // ==========================================================================
  // Command codes and unlock cycles
  // fixed codes
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR   = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR   = 21'h0002AA;
  localparam logic [7:0]        UNLOCK1_DATA   = 8'hAA;
  localparam logic [7:0]        UNLOCK2_DATA   = 8'h55;
  localparam logic [7:0]        CMD_RESET      = 8'hF0;
  localparam logic [7:0]        CMD_AUTOSEL    = 8'h90;
  localparam logic [7:0]        CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]        CMD_BYPASS     = 8'h20;
  localparam logic [7:0]        CMD_BYP_RESET  = 8'h90;
  localparam logic [7:0]        CMD_BYP_EXIT   = 8'h00;
  localparam logic [7:0]        CMD_AUX_ENTER  = 8'h88;
  localparam logic [7:0]        CMD_AUX_EXIT1  = 8'h90;
  localparam logic [7:0]        CMD_AUX_EXIT2  = 8'h00;

  // ==========================================================================
  // Autoselect offsets
  localparam logic [7:0] AS_MAKER_OFS    = 8'h00;
  localparam logic [7:0] AS_DEV_OFS_WORD = 8'h01;
  localparam logic [7:0] AS_DEV_OFS_BYTE = 8'h02;
  localparam logic [7:0] AS_PROT_OFS_WORD = 8'h02;
  localparam logic [7:0] AS_PROT_OFS_BYTE = 8'h04;

  // ==========================================================================
  // Status bit positions
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;

  // ==========================================================================
  // Host register map (word index)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // ==========================================================================
  // Command opcodes written to CTRL[3:0]
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_READ     = 4'h1,
    OP_RESET    = 4'h2,
    OP_AUTOSEL  = 4'h3,
    OP_PROGRAM  = 4'h4,
    OP_BYPASS   = 4'h5,
    OP_BYP_PROG = 4'h6,
    OP_BYP_EXIT = 4'h7,
    OP_AUX_IN   = 4'h8,
    OP_AUX_OUT  = 4'h9,
    OP_RAW      = 4'hA
  } fbc_op_t;

  // ==========================================================================
  // Timing at 10 MHz
  localparam int CLK_NS      = 100;
  localparam int T_STROBE_NS = 100;
  localparam int T_ACCESS_NS = 200;
  localparam logic [3:0] STROBE_CYC =
    4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACCESS_CYC =
    4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] POLL_LIMIT = 16'hFFFF;

  // ==========================================================================
  // One bus cycle on the flash pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbc_cycle_t;

  // Status word
  typedef struct packed {
    logic       busy;
    logic       timeout;
    logic       prog_fail;
    logic       in_bypass;
    logic       in_autosel;
    logic       in_aux;
    logic       accel;
    logic       rdy;
  } fbc_status_t;

endpackage

// >>> test/fbc_host_sva.sv
`timescale 1ns/100ps
module fbc_host_chk (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset_n,
  // Flash pins
  input wire logic [fbc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fbc_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic                       flash_dq_oe,
  input wire logic                       flash_ce_n,
  input wire logic                       flash_we_n,
  input wire logic                       flash_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ========================
  // Write cycle shape
  sequence pulse_s;
    !flash_we_n ##1 !flash_we_n ##1 flash_we_n;
  endsequence
  sequence hold_s;
    ($stable(flash_addr) && $stable(flash_dq_out)) [*2];
  endsequence
  we_in_ce_a: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without chip select");
  oe_in_ce_a: assert property (!flash_oe_n |-> !flash_ce_n)
    else $error("output enable without chip select");
  no_clash_a: assert property (!flash_we_n |-> flash_oe_n)
    else $error("write and read strobes together");
  data_drive_a: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data bus not driven during write");
  read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data bus driven during read");
  pulse_len_a: assert property ($fell(flash_we_n) |-> pulse_s)
    else $error("write pulse length wrong");
  cycle_hold_a: assert property ($fell(flash_we_n) |=> hold_s)
    else $error("address or data moved during write");
  ce_setup_a: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n))
    else $error("chip select not set up before write");
  reset_idle_a: assert property ($rose(reset_n) |->
    flash_ce_n && flash_we_n && flash_oe_n && !flash_dq_oe)
    else $error("flash pins not idle after reset");
endmodule

bind fbc_host fbc_host_chk chk (
  .clk, .reset_n, .flash_addr, .flash_dq_out,
  .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n
);

// >>> test/fbc_flash_model.sv
`timescale 1ns/100ps
module fbc_flash_model #(
  parameter int          T_PROG = 3000,
  parameter logic [15:0] MAKER  = 16'h00C1,  // Arbitrary value
  parameter logic [15:0] DEVID  = 16'h00D2   // Arbitrary value
) (
  // Bus
  input  wire logic [fbc_pkg::ADDR_W-1:0] addr,
  input  wire logic [fbc_pkg::DATA_W-1:0] dq,
  output logic      [fbc_pkg::DATA_W-1:0] dq_drv,
  // Control
  input  wire logic                       ce_n,
  input  wire logic                       we_n,
  input  wire logic                       oe_n,
  input  wire logic                       rst_n,
  input  wire logic                       acc,
  output logic                            rb_n
);
  logic [15:0]                mem [64];
  logic [15:0]                d_lat, p_data, val, last;
  logic [fbc_pkg::ADDR_W-1:0] a_lat, p_addr;
  logic [2:0]                 st;
  logic                       busy, asel, aux, byp, tog, pend;
  task automatic clr();
    st   = 3'h0;
    busy = 1'b0;
    asel = 1'b0;
    aux  = 1'b0;
    byp  = 1'b0;
    pend = 1'b0;
  endtask
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'hFF00 | 16'(i);
    last = 16'h0000;
    tog  = 1'b0;
    clr();
  end
  always @(negedge rst_n) clr();
  task automatic cmd();
    logic [7:0] d;
    d = d_lat[7:0];
    if (busy) return;
    if (st == 3'h3) begin
      p_addr = a_lat;
      p_data = d_lat;
      busy   = 1'b1;
      st     = 3'h0;
    end else if (d == fbc_pkg::CMD_RESET && !byp) begin
      // reset command ends autoselect and returns bank to array reads unless bypass is set; aux mode still overrides reads
      st   = 3'h0;
      asel = 1'b0;
    end else if (byp) begin
      byp = !(st == 3'h5 && d == fbc_pkg::CMD_BYP_EXIT);
      st  = d == fbc_pkg::CMD_PROGRAM ? 3'h3 : d == fbc_pkg::CMD_BYP_RESET ? 3'h5 : 3'h0;
    end else if (st == 3'h0) begin
      st = {2'b00, a_lat == fbc_pkg::UNLOCK1_ADDR && d == fbc_pkg::UNLOCK1_DATA};
    end else if (st == 3'h1) begin
      st = (a_lat == fbc_pkg::UNLOCK2_ADDR && d == fbc_pkg::UNLOCK2_DATA) ? 3'h2 : 3'h0;
    end else if (st == 3'h2) begin
      st   = d == fbc_pkg::CMD_PROGRAM ? 3'h3 :
             (aux && d == fbc_pkg::CMD_AUX_EXIT1) ? 3'h4 : 3'h0;
      byp  = d == fbc_pkg::CMD_BYPASS;
      asel = asel || (!aux && d == fbc_pkg::CMD_AUTOSEL);
      aux  = aux || d == fbc_pkg::CMD_AUX_ENTER;
    end else begin
      aux = d != fbc_pkg::CMD_AUX_EXIT2;
      st  = 3'h0;
    end
  endtask
  // address at later fall, data 50 ns after that fall, command at first rise
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n) begin
      a_lat = addr;
      pend  = 1'b1;
      #50 d_lat = dq;
    end
  end
  always @(posedge we_n or posedge ce_n) begin
    if (pend && rst_n) cmd();
    pend = 1'b0;
  end
  always @(posedge busy) begin
    #(T_PROG);
    if (busy) mem[p_addr[5:0]] = mem[p_addr[5:0]] & p_data;
    busy = 1'b0;
  end
  // read paths, bypass on high voltage
  always @(posedge acc) byp = 1'b1;
  always @(negedge oe_n) tog = ~tog;
  always @* begin
    if (busy) val = {8'h00, ~p_data[7], tog, 6'h00};
    else if (aux) val = 16'hA5A5;
    else if (asel) val = addr[7:0] == 8'h00 ? MAKER : addr[7:0] == 8'h01 ? DEVID : 16'h0000;
    else val = mem[addr[5:0]];
  end
  always @(posedge oe_n) last = val;
  assign dq_drv = (!ce_n && !oe_n && rst_n) ? val : ~last;
  assign rb_n   = !busy;
endmodule

// >>> test/fbc_host_tb.sv
`timescale 1ns/100ps
module fbc_host_tb;
  logic                       clk, reset_n, reg_wr, reg_rd;
  logic [3:0]                 reg_addr;
  logic [31:0]                reg_wdata, reg_rdata, rd_val;
  logic [fbc_pkg::ADDR_W-1:0] flash_addr;
  logic [fbc_pkg::DATA_W-1:0] dq_bus, flash_dq_out, dq_drv;
  logic                       flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic                       flash_reset_n, byte_word_select, accel, rb_n;
  int                         err_total, checks_done;
  assign dq_bus = flash_dq_oe ? flash_dq_out : dq_drv;
  fbc_host dut (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr,
    .flash_dq_in(dq_bus), .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .flash_reset_n, .byte_word_select, .protect_accelerate_input(accel),
    .ready_busy_n_output(rb_n)
  );
  fbc_flash_model flash (
    .addr(flash_addr), .dq(dq_bus), .dq_drv, .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .rst_n(flash_reset_n), .acc(accel), .rb_n
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ========================
  // Shared tasks
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", w, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rd_val = reg_rdata;
  endtask
  task automatic op(input logic [6:0] c, input logic [20:0] a, input logic [15:0] d);
    int n;
    wr(fbc_pkg::REG_ADDR, 32'(a));
    wr(fbc_pkg::REG_WDATA, 32'(d));
    wr(fbc_pkg::REG_CTRL, 32'(c));
    n = 0;
    rd(fbc_pkg::REG_STATUS);
    while (rd_val[7] !== 1'b0 && n < 3000) begin
      rd(fbc_pkg::REG_STATUS);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic fchk(input string w, input logic [20:0] a, input logic [15:0] e);
    op(fbc_pkg::OP_READ, a, 16'h0000);
    rd(fbc_pkg::REG_RDATA);
    check(w, 32'(e), rd_val);
  endtask
  // ========================
  // Scenarios
  task automatic s_power();
    fchk("array", 21'h000005, 16'hFF05);
    check("reset pin idle", 32'h00000001, {31'h0, flash_reset_n});
    check("word select", 32'h00000001, {31'h0, byte_word_select});
    rd(4'hF);
    check("unmapped", 32'h00000000, rd_val);
  endtask
  task automatic s_program();
    op(fbc_pkg::OP_PROGRAM, 21'h000010, 16'h1234);
    rd(fbc_pkg::REG_STATUS);
    check("prog flags", 32'h00000000, {30'h0, rd_val[6:5]});
    fchk("prog", 21'h000010, 16'h1210);
    op(fbc_pkg::OP_PROGRAM, 21'h000010, 16'hFF7F);
    fchk("reprog", 21'h000010, 16'h1210);
  endtask
  task automatic s_autosel();
    op(fbc_pkg::OP_AUTOSEL, 21'h000000, 16'h0000);
    rd(fbc_pkg::REG_STATUS);
    check("autosel mode", 32'h00000001, {31'h0, rd_val[3]});
    fchk("maker", 21'h000000, flash.MAKER);
    fchk("device", 21'h000001, flash.DEVID);
    fchk("protect", 21'h000002, 16'h0000);
    op(fbc_pkg::OP_RESET, 21'h1F3C5, 16'h0000);
    fchk("after reset", 21'h000001, 16'hFF01);
    rd(fbc_pkg::REG_STATUS);
    check("autosel left", 32'h00000000, {31'h0, rd_val[3]});
  endtask
  task automatic s_bypass();
    op(fbc_pkg::OP_BYPASS, 21'h000000, 16'h0000);
    op(fbc_pkg::OP_BYP_PROG, 21'h000020, 16'h0025);
    op(fbc_pkg::OP_BYP_PROG, 21'h000021, 16'h5A5A);
    op(fbc_pkg::OP_BYP_EXIT, 21'h000000, 16'h0000);
    fchk("byp a", 21'h000020, 16'h0020);
    fchk("byp b", 21'h000021, 16'h5A00);
    wr(fbc_pkg::REG_CTRL, 32'h00000020);
    rd(fbc_pkg::REG_STATUS);
    check("accel pin", 32'h00000001, {31'h0, accel});
    check("accel bypass", 32'h00000001, {31'h0, rd_val[4]});
    op(7'h26, 21'h000022, 16'h0022);
    op(fbc_pkg::OP_BYP_EXIT, 21'h000000, 16'h0000);
    fchk("accel prog", 21'h000022, 16'h0022);
  endtask
  task automatic s_aux();
    op(fbc_pkg::OP_AUX_IN, 21'h000000, 16'h0000);
    fchk("aux", 21'h000003, 16'hA5A5);
    op(fbc_pkg::OP_AUX_OUT, 21'h000000, 16'h0000);
    fchk("aux out", 21'h000003, 16'hFF03);
    op(fbc_pkg::OP_AUX_IN, 21'h000000, 16'h0000);
    wr(fbc_pkg::REG_CTRL, 32'h00000050);
    check("reset pin", 32'h00000000, {31'h0, flash_reset_n});
    check("byte select", 32'h00000000, {31'h0, byte_word_select});
    wr(fbc_pkg::REG_CTRL, 32'h00000000);
    fchk("hw reset", 21'h000003, 16'hFF03);
  endtask
  initial begin
    err_total   = 0;
    checks_done = 0;
    reset_n     = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h00000000;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    s_power();
    s_program();
    s_autosel();
    s_bypass();
    s_aux();
    stop_test();
  end
endmodule
